// [common/dlct_cfg.svh]
// Register indices, field positions and reset values of the dual counter/timer
`ifndef DLCT_CFG_SVH
`define DLCT_CFG_SVH

// Register indices; the byte address is four times the index
`define DLCT_IDX_CTRL      10'h088
`define DLCT_IDX_MODE      10'h089
`define DLCT_IDX_T0_LOW    10'h08A
`define DLCT_IDX_T1_LOW    10'h08B
`define DLCT_IDX_T0_HIGH   10'h08C
`define DLCT_IDX_T1_HIGH   10'h08D
`define DLCT_IDX_PRESCALE  10'h08E

// Control register fields
`define DLCT_CTRL_TF1      7
`define DLCT_CTRL_TR1      6
`define DLCT_CTRL_TF0      5
`define DLCT_CTRL_TR0      4
`define DLCT_CTRL_IE1      3
`define DLCT_CTRL_IT1      2
`define DLCT_CTRL_IE0      1
`define DLCT_CTRL_IT0      0

// Mode register fields
`define DLCT_MODE_GATE1    7
`define DLCT_MODE_SRC1     6
`define DLCT_MODE_M1_HI    5
`define DLCT_MODE_M1_LO    4
`define DLCT_MODE_FIRST_TIMER_GATE_ENABLE    3
`define DLCT_MODE_SRC0     2
`define DLCT_MODE_M0_HI    1
`define DLCT_MODE_M0_LO    0

// Prescale register fields
`define DLCT_PRE_T0M       3
`define DLCT_PRE_T1M       4

// Reset values
`define DLCT_RST_BYTE      8'h00
`define DLCT_RST_WORD      32'h0000_0000

// Slow tick divisor
`define DLCT_SLOW_DIV      12

// Low five bits used in the 13-bit mode
`define DLCT_M13_LOW_W     5

`endif

// [common/dlct_pin_if.sv]
// Carrier between a pin sampler and the timer core
`timescale 1ns/10ps
`default_nettype none
interface dlct_pin_if;
  logic pin;
  logic level;
  logic fall;
  modport sampler (input pin, output level, output fall);
  modport user    (output pin, input level, input fall);
endinterface
`default_nettype wire

// [common/dlct_pkg.sv]
// Types shared by the dual counter/timer design files
package dlct_pkg;

  // Operating mode of one timer
  typedef enum logic [1:0] {
    DLCT_M13   = 2'h0,
    DLCT_M16   = 2'h1,
    DLCT_M8R   = 2'h2,
    DLCT_SPLIT = 2'h3
  } dlct_mode_e;

  // Bus slave phase, one-hot
  typedef enum logic [2:0] {
    DLCT_BUS_IDLE = 3'b001,
    DLCT_BUS_WR   = 3'b010,
    DLCT_BUS_RD   = 3'b100
  } dlct_bus_e;

  // Result of one counting step
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } dlct_step_s;

endpackage

// [dv/dlct_pins_model.sv]
// Model of the external count and gate pins
`timescale 1ns/10ps
`default_nettype none
module dlct_pins_model (
  input  wire logic       hclk,
  output var  logic [1:0] cnt,
  output var  logic [1:0] gate
);
  // Pins idle high, so a sampler sees no fall at release
  initial begin
    cnt  = 2'b11;
    gate = 2'b11;
  end
  task automatic falls(input int k, input int n);
    repeat (n) begin
      @(posedge hclk) cnt[k] <= 1'b0;
      repeat (3) @(posedge hclk);
      cnt[k] <= 1'b1;
      repeat (3) @(posedge hclk);
    end
  endtask
  // Gate move, then settle
  task automatic set_gate(input int k, input logic v);
    @(posedge hclk) gate[k] <= v;
    repeat (4) @(posedge hclk);
  endtask
endmodule // dlct_pins_model
`default_nettype wire

// [dv/dlct_top_assertions.sv]
// Port checker for the dual counter/timer
`timescale 1ns/10ps
`default_nettype none
`include "dlct_cfg.svh"
module dlct_top_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              first_external_gate_pin,
  input wire logic              second_external_gate_pin,
  input wire logic              first_timer_vector_ack,
  input wire logic              second_timer_vector_ack,
  input wire logic              first_timer_overflow_flag,
  input wire logic              second_timer_overflow_flag,
  input wire logic              first_ext_irq_flag,
  input wire logic              second_ext_irq_flag,
  input wire logic              second_timer_baud_pulse
);
  logic       tk;
  logic       wr_dp;
  logic [9:0] a_q;
  logic [7:0] ctl_sh;
  logic [7:0] mod_sh;
  assign tk = hsel && htrans[1] && hready;
  // Software-owned bit shadows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp  <= 1'b0;
      a_q    <= 10'h000;
      ctl_sh <= 8'h00;
      mod_sh <= 8'h00;
    end else begin
      wr_dp <= tk && hwrite;
      if (tk) a_q <= haddr[11:2];
      if (wr_dp && a_q == `DLCT_IDX_CTRL) ctl_sh <= hwdata[7:0];
      if (wr_dp && a_q == `DLCT_IDX_MODE) mod_sh <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait");
  chk_write_nowait: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("upper bits");
  chk_mode_back: assert property (tk && !hwrite && haddr[11:2] == `DLCT_IDX_MODE |-> ##2 hrdata[7:0] == mod_sh)
    else $error("mode readback");
  chk_ovf0_sticky: assert property ($fell(first_timer_overflow_flag) |-> $past(first_timer_vector_ack) || $past(wr_dp))
    else $error("ovf0 dropped");
  chk_ovf1_sticky: assert property ($fell(second_timer_overflow_flag) |-> $past(second_timer_vector_ack) || $past(wr_dp))
    else $error("ovf1 dropped");
  chk_ext0_level: assert property (!ctl_sh[0] [*4] |-> first_ext_irq_flag == !$past(first_external_gate_pin, 2))
    else $error("ext0 level");
  chk_ext1_level: assert property (!ctl_sh[2] [*4] |-> second_ext_irq_flag == !$past(second_external_gate_pin, 2))
    else $error("ext1 level");
  cov_ovf0: cover property ($rose(first_timer_overflow_flag));
  cov_baud: cover property (second_timer_baud_pulse);
  cov_edge: cover property ($rose(first_ext_irq_flag) && ctl_sh[0]);
endmodule // dlct_top_assertions
bind dlct_top dlct_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// [dv/tb_dlct_top.sv]
// Register-level testbench of the dual counter/timer
`timescale 1ns/10ps
`default_nettype none
`include "dlct_cfg.svh"
module tb_dlct_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans, cnt, gate;
  logic [31:0] hwdata, hrdata;
  logic [3:0]  ack;
  logic        ovf0, ovf1, ext0, ext1, baud;
  logic [7:0]  v, h;
  int          errors, n_compared, n_baud, nb;
  dlct_pins_model u_pins (.hclk(hclk), .cnt(cnt), .gate(gate));
  dlct_top #(.ADDR_W(12)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .first_timer_count_pin(cnt[0]), .second_timer_count_pin(cnt[1]),
    .first_external_gate_pin(gate[0]), .second_external_gate_pin(gate[1]),
    .first_timer_vector_ack(ack[0]), .second_timer_vector_ack(ack[1]),
    .first_ext_vector_ack(ack[2]), .second_ext_vector_ack(ack[3]),
    .first_timer_overflow_flag(ovf0), .second_timer_overflow_flag(ovf1),
    .first_ext_irq_flag(ext0), .second_ext_irq_flag(ext1), .second_timer_baud_pulse(baud));
  // 100 ns clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Overflow pulses seen on the baud output
  always @(posedge hclk) if (baud === 1'b1) n_baud++;
  task automatic end_of_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Wait for hready, bounded
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic [9:0] i, input logic w, input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {i, 2'h0};
    wt();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
    wt();
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    xfer(i, 1'b1, d, q);
  endtask
  // Read and compare the bits under mask m
  task automatic rc(input logic [9:0] i, input logic [7:0] m, input logic [7:0] e, input string s);
    logic [7:0] q;
    xfer(i, 1'b0, 8'h00, q);
    chk(s, q & m, e);
  endtask
  task automatic pulse(input int k);
    @(posedge hclk) ack[k] <= 1'b1;
    @(posedge hclk) ack[k] <= 1'b0;
    @(posedge hclk);
  endtask
  // Watchdog, far past the run
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    end_of_test();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 12'h000; htrans = 2'h0; hwdata = 32'h0; ack = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`DLCT_IDX_CTRL, 8'hFF, 8'h00, "ctrl reset");
    rc(`DLCT_IDX_MODE, 8'hFF, 8'h00, "mode reset");
    rc(10'h090, 8'hFF, 8'h00, "unmapped");
    wr(`DLCT_IDX_PRESCALE, 8'h18);
    // 13-bit counting of pin falls, preloaded before start
    wr(`DLCT_IDX_MODE, 8'h04); wr(`DLCT_IDX_T0_LOW, 8'h1E); wr(`DLCT_IDX_T0_HIGH, 8'hFF);
    wr(`DLCT_IDX_CTRL, 8'h10);
    rc(`DLCT_IDX_T0_LOW, 8'h1F, 8'h1E, "start keeps count");
    u_pins.falls(0, 1); rc(`DLCT_IDX_T0_LOW, 8'h1F, 8'h1F, "low five");
    u_pins.falls(0, 1); rc(`DLCT_IDX_T0_HIGH, 8'hFF, 8'h00, "high wrap");
    rc(`DLCT_IDX_CTRL, 8'h20, 8'h20, "ovf0 13b");
    pulse(0); chk("ovf0 ack", {7'h0, ovf0}, 8'h00);
    // Gated 16-bit count
    wr(`DLCT_IDX_MODE, 8'h0D); wr(`DLCT_IDX_T0_LOW, 8'hFF); wr(`DLCT_IDX_T0_HIGH, 8'h00);
    u_pins.set_gate(0, 1'b0); u_pins.falls(0, 1);
    rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'hFF, "gate low holds");
    u_pins.set_gate(0, 1'b1); u_pins.falls(0, 1);
    rc(`DLCT_IDX_T0_HIGH, 8'hFF, 8'h01, "16b carry");
    rc(`DLCT_IDX_CTRL, 8'h20, 8'h00, "no ovf 16b");
    wr(`DLCT_IDX_CTRL, 8'h00); u_pins.falls(0, 1);
    rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'h00, "run off holds");
    // Auto-reload
    wr(`DLCT_IDX_MODE, 8'h06); wr(`DLCT_IDX_T0_HIGH, 8'hF0); wr(`DLCT_IDX_T0_LOW, 8'hFE);
    wr(`DLCT_IDX_CTRL, 8'h10); u_pins.falls(0, 2);
    rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'hF0, "reloaded");
    rc(`DLCT_IDX_CTRL, 8'h20, 8'h20, "ovf0 reload");
    u_pins.falls(0, 1); rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'hF1, "low counts");
    rc(`DLCT_IDX_T0_HIGH, 8'hFF, 8'hF0, "reload kept");
    wr(`DLCT_IDX_CTRL, 8'h10); rc(`DLCT_IDX_CTRL, 8'h20, 8'h00, "ovf0 write zero");
    // Second timer, 16-bit on its pin
    wr(`DLCT_IDX_MODE, 8'h50); wr(`DLCT_IDX_T1_LOW, 8'hFF); wr(`DLCT_IDX_T1_HIGH, 8'hFF);
    wr(`DLCT_IDX_CTRL, 8'h40); nb = n_baud; u_pins.falls(1, 1);
    rc(`DLCT_IDX_T1_HIGH, 8'hFF, 8'h00, "t1 wrap");
    chk("ovf1", {7'h0, ovf1}, 8'h01);
    chk("baud once", 8'(n_baud - nb), 8'h01);
    // Split: high byte on the second run bit
    wr(`DLCT_IDX_CTRL, 8'h00); wr(`DLCT_IDX_MODE, 8'h67);
    wr(`DLCT_IDX_T0_LOW, 8'h10); wr(`DLCT_IDX_T0_HIGH, 8'hF0); wr(`DLCT_IDX_CTRL, 8'h40);
    repeat (40) @(posedge hclk);
    rc(`DLCT_IDX_CTRL, 8'h80, 8'h80, "split high ovf");
    rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'h10, "split low idle");
    wr(`DLCT_IDX_CTRL, 8'h10); xfer(`DLCT_IDX_T0_HIGH, 1'b0, 8'h00, h); u_pins.falls(0, 2);
    rc(`DLCT_IDX_T0_HIGH, 8'hFF, h, "split high stopped");
    rc(`DLCT_IDX_T0_LOW, 8'hFF, 8'h12, "split low pins");
    nb = n_baud; wr(`DLCT_IDX_T1_HIGH, 8'hFF);
    repeat (300) @(posedge hclk);
    chk("split baud", {7'h0, n_baud > nb}, 8'h01);
    rc(`DLCT_IDX_CTRL, 8'h80, 8'h00, "split t1 no flag");
    // Second timer mode three stops it
    wr(`DLCT_IDX_MODE, 8'h30); wr(`DLCT_IDX_T1_LOW, 8'h05); wr(`DLCT_IDX_CTRL, 8'h40);
    repeat (30) @(posedge hclk);
    rc(`DLCT_IDX_T1_LOW, 8'hFF, 8'h05, "t1 mode3 stop");
    wr(`DLCT_IDX_MODE, 8'h10); repeat (30) @(posedge hclk);
    xfer(`DLCT_IDX_T1_LOW, 1'b0, 8'h00, v); chk("t1 restarts", {7'h0, v == 8'h05}, 8'h00);
    // External flags, edge then level
    wr(`DLCT_IDX_CTRL, 8'h01); u_pins.set_gate(0, 1'b0); u_pins.set_gate(0, 1'b1);
    chk("edge latched", {7'h0, ext0}, 8'h01);
    pulse(2); chk("edge ack", {7'h0, ext0}, 8'h00);
    u_pins.set_gate(1, 1'b0); chk("level low", {7'h0, ext1}, 8'h01);
    u_pins.set_gate(1, 1'b1); chk("level high", {7'h0, ext1}, 8'h00);
    // Second reset in mid-run
    hresetn <= 1'b0; repeat (3) @(posedge hclk); hresetn <= 1'b1; @(posedge hclk);
    rc(`DLCT_IDX_CTRL, 8'hFF, 8'h00, "ctrl rereset");
    end_of_test();
  end
endmodule // tb_dlct_top
`default_nettype wire

// [hw/dlct_pin_sampler.sv]
// Samples one pin and flags its high-to-low transitions
`timescale 1ns/10ps
`default_nettype none
module dlct_pin_sampler (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  dlct_pin_if.sampler bus
);
  logic prev;

  // Two stages so a level held two clocks is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.level <= 1'b1;
      prev      <= 1'b1;
    end else begin
      bus.level <= bus.pin;
      prev      <= bus.level;
    end
  end

  // Fall pulse for exactly one clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus.fall <= 1'b0;
    end else begin
      bus.fall <= prev & ~bus.level;
    end
  end
endmodule // dlct_pin_sampler
`default_nettype wire

// [hw/dlct_top.sv]
// Dual legacy counter/timer with its control register, reached over AHB-Lite
// How it works
// R1: Second timer mirrors first, except split mode
// R2: 13-bit mode: high byte, low five bits
// R3: Software masks undefined top three low bits
// R4: 13-bit wrap sets the overflow flag
// R5: Source bit picks ticks or pin falls
// R6: Count when run and gate allows
// R7: Run bit leaves the count untouched
// R8: 16-bit mode uses both full bytes
// R9: Auto-reload: low counts, high reloads
// R10: Low wrap sets flag, reloads from high
// R11: Reload byte never changed by hardware
// R12: Software preloads low byte before start
// R13: Split mode low byte uses first bits
// R14: Split high byte counts ticks only
// R15: Split high byte run by second run bit
// R16: Split high overflow sets second flag
// R17: Second timer mode three stops it
// R18: Under split, second timer: no pin, flag
// R19: Second timer overflow still pulses out
// R20: Tick is clock divided by one or twelve
// R21: Pin levels held two clocks each
// R22: Overflow flags clear on write-zero or vector
// R23: External flags: level follows pin, edge latches
`timescale 1ns/10ps
`default_nettype none
`include "dlct_cfg.svh"
module dlct_top #(
  parameter int ADDR_W   = 12,
  parameter int SLOW_DIV = `DLCT_SLOW_DIV
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  input  wire logic              first_timer_count_pin,
  input  wire logic              second_timer_count_pin,
  input  wire logic              first_external_gate_pin,
  input  wire logic              second_external_gate_pin,
  input  wire logic              first_timer_vector_ack,
  input  wire logic              second_timer_vector_ack,
  input  wire logic              first_ext_vector_ack,
  input  wire logic              second_ext_vector_ack,
  output var  logic              first_timer_overflow_flag,
  output var  logic              second_timer_overflow_flag,
  output var  logic              first_ext_irq_flag,
  output var  logic              second_ext_irq_flag,
  output var  logic              second_timer_baud_pulse
);
  import dlct_pkg::*;

  // Elaboration checks
  generate
    if (ADDR_W < 12) begin : g_bad_addr
      $error("dlct_top: ADDR_W must be at least 12");
    end
    if (SLOW_DIV < 2 || SLOW_DIV > 16) begin : g_bad_div
      $error("dlct_top: SLOW_DIV must lie in 2..16");
    end
  endgenerate

  localparam logic [3:0] DIV_LAST = 4'(SLOW_DIV - 1);
  localparam int         NPINS    = 4;

  // Stored state
  logic [7:0] timer_mode_select_register;
  logic [7:0] tick_prescale_register;
  logic [7:0] first_timer_low_byte;
  logic [7:0] first_timer_high_byte;
  logic [7:0] second_timer_low_byte;
  logic [7:0] second_timer_high_byte;
  logic       first_timer_run_bit;
  logic       second_timer_run_bit;
  logic       first_ext_irq_type;
  logic       second_ext_irq_type;
  logic [3:0] div_cnt;
  dlct_bus_e  bus_state;
  logic [9:0] addr_q;

  // Pin samplers: 0 count0, 1 count1, 2 gate0, 3 gate1
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_lvl;
  logic [NPINS-1:0] pin_fall;
  dlct_pin_if pin_if [NPINS] ();

  assign pin_raw = {second_external_gate_pin, first_external_gate_pin,
                    second_timer_count_pin, first_timer_count_pin};

  // R21: two-stage sampling
  generate
    for (genvar i = 0; i < NPINS; i++) begin : g_pins
      assign pin_if[i].pin = pin_raw[i];
      assign pin_lvl[i]    = pin_if[i].level;
      assign pin_fall[i]   = pin_if[i].fall;
      dlct_pin_sampler u_samp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bus     (pin_if[i])
      );
    end
  endgenerate

  // One counting step of a whole timer in modes 0 to 2
  function automatic dlct_step_s dlct_step(input dlct_mode_e mode, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic inc);
    dlct_step_s r;
    r.low  = lo;
    r.high = hi;
    r.ovf  = 1'b0;
    if (inc) begin
      case (mode)
        // R2: 13-bit, top low bits kept as they were
        DLCT_M13: begin
          if (&lo[`DLCT_M13_LOW_W-1:0]) begin
            r.low[`DLCT_M13_LOW_W-1:0] = '0;
            r.high = hi + 8'h01;
            // R4: wrap from all ones sets flag
            r.ovf  = &hi;
          end else begin
            r.low[`DLCT_M13_LOW_W-1:0] = lo[`DLCT_M13_LOW_W-1:0] + 5'h01;
          end
        end
        // R8: full sixteen bits
        DLCT_M16: begin
          r.low = lo + 8'h01;
          if (&lo) begin
            r.high = hi + 8'h01;
            r.ovf  = &hi;
          end
        end
        // R9: low counts, high holds reload
        DLCT_M8R: begin
          // R10: reload on wrap
          if (&lo) begin
            r.low = hi;
            r.ovf = 1'b1;
          end else begin
            r.low = lo + 8'h01;
          end
        end
        // R11: high byte never touched here
        default: begin
          r.low = lo + 8'h01;
          r.ovf = &lo;
        end
      endcase
    end
    return r;
  endfunction

  // Mode decode
  dlct_mode_e t0_mode;
  dlct_mode_e t1_mode;
  logic       t0_split;
  assign t0_mode  = dlct_mode_e'(timer_mode_select_register[`DLCT_MODE_M0_HI:`DLCT_MODE_M0_LO]);
  assign t1_mode  = dlct_mode_e'(timer_mode_select_register[`DLCT_MODE_M1_HI:`DLCT_MODE_M1_LO]);
  assign t0_split = (t0_mode == DLCT_SPLIT);

  // R20: shared divide-by-twelve prescaler
  logic slow_tick;
  assign slow_tick = (div_cnt == DIV_LAST);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= slow_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // R20: per-timer tick select
  logic tick0;
  logic tick1;
  assign tick0 = tick_prescale_register[`DLCT_PRE_T0M] | slow_tick;
  assign tick1 = tick_prescale_register[`DLCT_PRE_T1M] | slow_tick;

  // R6: run and gate qualify counting
  logic run0;
  logic run1;
  assign run0 = first_timer_run_bit &
                (~timer_mode_select_register[`DLCT_MODE_FIRST_TIMER_GATE_ENABLE] | pin_lvl[2]);
  // R17: mode three halts the second timer; under split it needs no run bit and runs unless in mode three or gated off
  assign run1 = (t1_mode != DLCT_SPLIT) & (t0_split | second_timer_run_bit) &
                (~timer_mode_select_register[`DLCT_MODE_GATE1] | pin_lvl[3]);

  // R5: source select, R13: also governs split low byte
  logic inc0;
  logic inc1;
  logic inc0_hi;
  assign inc0 = run0 & (timer_mode_select_register[`DLCT_MODE_SRC0] ? pin_fall[0] : tick0);
  // R18: no external counting under split
  assign inc1 = run1 &
                ((timer_mode_select_register[`DLCT_MODE_SRC1] & ~t0_split) ? pin_fall[1] : tick1);
  // R14: ticks only, R15: second run bit starts it
  assign inc0_hi = t0_split & second_timer_run_bit & tick0;

  // Next counts
  dlct_step_s step0;
  dlct_step_s step1;
  logic [7:0] next_t0_high;
  logic       t0_hi_ovf;
  assign step0 = dlct_step(t0_mode, first_timer_low_byte, first_timer_high_byte, inc0);
  // R1: same step for the second timer
  assign step1 = dlct_step(t1_mode, second_timer_low_byte, second_timer_high_byte, inc1);

  // Split high byte as its own 8-bit timer
  always_comb begin
    next_t0_high = step0.high;
    t0_hi_ovf    = 1'b0;
    if (inc0_hi) begin
      next_t0_high = first_timer_high_byte + 8'h01;
      t0_hi_ovf    = &first_timer_high_byte;
    end
  end

  // Bus data-phase write strobes
  logic wr_fire;
  logic wr_ctrl;
  assign wr_fire = (bus_state == DLCT_BUS_WR);
  assign wr_ctrl = wr_fire && (addr_q == `DLCT_IDX_CTRL);

  // AHB-Lite slave: writes zero-wait, reads one wait state so data come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= DLCT_BUS_IDLE;
      addr_q    <= 10'h000;
      hreadyout <= 1'b1;
    end else begin
      case (bus_state)
        DLCT_BUS_RD: begin
          bus_state <= DLCT_BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          if (hsel && htrans[1] && hready) begin
            addr_q    <= haddr[11:2];
            bus_state <= hwrite ? DLCT_BUS_WR : DLCT_BUS_RD;
            hreadyout <= hwrite;
          end else begin
            bus_state <= DLCT_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Control register image
  logic [7:0] ctrl_rd;
  always_comb begin
    ctrl_rd                   = 8'h00;
    ctrl_rd[`DLCT_CTRL_TF1]   = second_timer_overflow_flag;
    ctrl_rd[`DLCT_CTRL_TR1]   = second_timer_run_bit;
    ctrl_rd[`DLCT_CTRL_TF0]   = first_timer_overflow_flag;
    ctrl_rd[`DLCT_CTRL_TR0]   = first_timer_run_bit;
    ctrl_rd[`DLCT_CTRL_IE1]   = second_ext_irq_flag;
    ctrl_rd[`DLCT_CTRL_IT1]   = second_ext_irq_type;
    ctrl_rd[`DLCT_CTRL_IE0]   = first_ext_irq_flag;
    ctrl_rd[`DLCT_CTRL_IT0]   = first_ext_irq_type;
  end

  // Read data latched in the wait cycle; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `DLCT_RST_WORD;
    end else if (bus_state == DLCT_BUS_RD) begin
      if (addr_q == `DLCT_IDX_CTRL) begin
        hrdata <= {24'h000000, ctrl_rd};
      end else if (addr_q == `DLCT_IDX_MODE) begin
        hrdata <= {24'h000000, timer_mode_select_register};
      end else if (addr_q == `DLCT_IDX_T0_LOW) begin
        // R3: top three bits are don't-care in 13-bit mode
        hrdata <= {24'h000000, first_timer_low_byte};
      end else if (addr_q == `DLCT_IDX_T1_LOW) begin
        hrdata <= {24'h000000, second_timer_low_byte};
      end else if (addr_q == `DLCT_IDX_T0_HIGH) begin
        hrdata <= {24'h000000, first_timer_high_byte};
      end else if (addr_q == `DLCT_IDX_T1_HIGH) begin
        hrdata <= {24'h000000, second_timer_high_byte};
      end else if (addr_q == `DLCT_IDX_PRESCALE) begin
        hrdata <= {24'h000000, tick_prescale_register};
      end else begin
        hrdata <= `DLCT_RST_WORD;
      end
    end
  end

  // Configuration bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_mode_select_register <= `DLCT_RST_BYTE;
      tick_prescale_register     <= `DLCT_RST_BYTE;
      first_timer_run_bit        <= 1'b0;
      second_timer_run_bit       <= 1'b0;
      first_ext_irq_type         <= 1'b0;
      second_ext_irq_type        <= 1'b0;
    end else if (wr_fire) begin
      if (addr_q == `DLCT_IDX_MODE) begin
        timer_mode_select_register <= hwdata[7:0];
      end else if (addr_q == `DLCT_IDX_PRESCALE) begin
        // Only the two clock-select bits exist
        tick_prescale_register[`DLCT_PRE_T0M] <= hwdata[`DLCT_PRE_T0M];
        tick_prescale_register[`DLCT_PRE_T1M] <= hwdata[`DLCT_PRE_T1M];
      end else if (addr_q == `DLCT_IDX_CTRL) begin
        // R7: run bits do not touch the count
        first_timer_run_bit  <= hwdata[`DLCT_CTRL_TR0];
        second_timer_run_bit <= hwdata[`DLCT_CTRL_TR1];
        first_ext_irq_type   <= hwdata[`DLCT_CTRL_IT0];
        second_ext_irq_type  <= hwdata[`DLCT_CTRL_IT1];
      end
    end
  end

  // First timer bytes; a software write wins over counting that cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_timer_low_byte  <= `DLCT_RST_BYTE;
      first_timer_high_byte <= `DLCT_RST_BYTE;
    end else begin
      first_timer_low_byte  <= (wr_fire && addr_q == `DLCT_IDX_T0_LOW) ? hwdata[7:0] : step0.low;
      first_timer_high_byte <= (wr_fire && addr_q == `DLCT_IDX_T0_HIGH) ? hwdata[7:0] : next_t0_high;
    end
  end

  // R1: second timer bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_timer_low_byte  <= `DLCT_RST_BYTE;
      second_timer_high_byte <= `DLCT_RST_BYTE;
    end else begin
      second_timer_low_byte  <= (wr_fire && addr_q == `DLCT_IDX_T1_LOW) ? hwdata[7:0] : step1.low;
      second_timer_high_byte <= (wr_fire && addr_q == `DLCT_IDX_T1_HIGH) ? hwdata[7:0] : step1.high;
    end
  end

  // Overflow sources
  logic set_tf0;
  logic set_tf1;
  logic clr_tf0;
  logic clr_tf1;
  assign set_tf0 = step0.ovf;
  // R16: split high byte drives the second flag; R18: second timer cannot
  assign set_tf1 = t0_split ? t0_hi_ovf : step1.ovf;
  assign clr_tf0 = first_timer_vector_ack | (wr_ctrl & ~hwdata[`DLCT_CTRL_TF0]);
  assign clr_tf1 = second_timer_vector_ack | (wr_ctrl & ~hwdata[`DLCT_CTRL_TF1]);

  // R22: sticky flags, set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_timer_overflow_flag  <= 1'b0;
      second_timer_overflow_flag <= 1'b0;
    end else begin
      first_timer_overflow_flag  <= (first_timer_overflow_flag & ~clr_tf0) | set_tf0 |
                                    (wr_ctrl & hwdata[`DLCT_CTRL_TF0]);
      second_timer_overflow_flag <= (second_timer_overflow_flag & ~clr_tf1) | set_tf1 |
                                    (wr_ctrl & hwdata[`DLCT_CTRL_TF1]);
    end
  end

  // R19: overflow pulse for baud use, even under split
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_timer_baud_pulse <= 1'b0;
    end else begin
      second_timer_baud_pulse <= step1.ovf;
    end
  end

  // R23: external flags, edge latched or level follows inverted pin
  logic clr_ie0;
  logic clr_ie1;
  assign clr_ie0 = first_ext_vector_ack | (wr_ctrl & ~hwdata[`DLCT_CTRL_IE0]);
  assign clr_ie1 = second_ext_vector_ack | (wr_ctrl & ~hwdata[`DLCT_CTRL_IE1]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_ext_irq_flag  <= 1'b0;
      second_ext_irq_flag <= 1'b0;
    end else begin
      first_ext_irq_flag  <= first_ext_irq_type ?
                             ((first_ext_irq_flag & ~clr_ie0) | pin_fall[2] |
                              (wr_ctrl & hwdata[`DLCT_CTRL_IE0])) : ~pin_lvl[2];
      second_ext_irq_flag <= second_ext_irq_type ?
                             ((second_ext_irq_flag & ~clr_ie1) | pin_fall[3] |
                              (wr_ctrl & hwdata[`DLCT_CTRL_IE1])) : ~pin_lvl[3];
    end
  end

  // Word size is assumed; narrower accesses act as words
  logic unused_ok;
  assign unused_ok = ^{hsize, htrans[0], hwdata[31:8], haddr};
endmodule // dlct_top
`default_nettype wire
